// File: ptic_conv_timer.sv
// conversion length down-counter, done marks the last cycle
`timescale 1ns/1ps
module ptic_conv_timer #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (start) begin
         cnt_d = load;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = (cnt_q == W'(1));
endmodule

// File: ptic_panel_model.sv
// resistive panel model seen from the X-plus pin
`timescale 1ns/1ps
module ptic_panel_model (
   input  wire logic touched,
   input  wire logic yminus_gnd_en,
   output logic      xplus_level
);
   // X-plus reaches ground only through the grounded Y-minus plate
   // untouched or ungrounded, the board pullup holds it high
   assign xplus_level = (touched && yminus_gnd_en) ? 1'b0 : 1'b1;
endmodule

// File: ptic_pen_irq.sv
// pen touch detection arming and touch interrupt pin control
`timescale 1ns/1ps
module ptic_pen_irq
   import ptic_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET_N,
   input  wire logic              ADDR_WR_ACK,
   input  wire logic              CMD_VALID,
   input  wire ptic_pkg::ptic_cmd_t CMD,
   input  wire logic              STOP_OR_RESTART,
   input  wire logic              XPLUS_IN,
   output logic                   TOUCH_IRQ_N_O,
   output logic                   TOUCH_IRQ_N_OE,
   output logic                   YMINUS_GND_EN,
   output logic                   XPLUS_IRQ_CONN,
   output logic                   PEN_ARMED,
   output logic                   CONV_BUSY
);
   import ptic_pkg::*;

   ptic_state_t state_q;
   ptic_state_t state_d;
   ptic_cmd_t   cmd_q;
   ptic_cmd_t   cmd_d;
   logic        armed_q;
   logic        armed_d;
   logic        eligible_q;
   logic        eligible_d;
   logic        force_low_q;
   logic        force_low_d;
   logic        measuring_q;
   logic        measuring_d;
   logic        irq_oe_q;
   logic        irq_oe_d;
   logic        ymin_q;
   logic        ymin_d;
   logic        xconn_q;
   logic        xconn_d;
   logic        busy_q;
   logic        busy_d;
   logic        irq_o_q;
   logic        conv_start;
   logic        conv_done;
   logic        conv_busy;

   ptic_conv_timer #(
      .W (CNT_W)
   ) u_timer (
      .clk   (CLK),
      .rst_n (RESET_N),
      .start (conv_start),
      .load  (conv_cycles(cmd_q.res_8bit)),
      .busy  (conv_busy),
      .done  (conv_done)
   );

   always_comb begin
      state_d     = state_q;
      cmd_d       = cmd_q;
      armed_d     = armed_q;
      eligible_d  = eligible_q;
      force_low_d = force_low_q;
      conv_start  = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (CMD_VALID) begin
               cmd_d   = CMD;
               state_d = ST_ACQUIRE;
            end
         end
         ST_ACQUIRE: begin
            if (STOP_OR_RESTART) begin
               conv_start = 1'b1;
               state_d    = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (conv_done) begin
               state_d = ST_IDLE;
               if (eligible_q) begin
                  armed_d = 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (CMD_VALID && state_q == ST_IDLE) begin
         eligible_d  = (CMD.power_down_select_low == PD_SEL_ARMS) && !is_driver_only(CMD.kind);
         force_low_d = is_driver_only(CMD.kind);
         if (!eligible_d) begin
            armed_d = 1'b0;
         end
      end
      // write address ack disarms, wins over re-arm
      if (ADDR_WR_ACK) begin
         armed_d    = 1'b0;
         eligible_d = 1'b0;
      end
   end

   always_comb begin
      // measuring while a measure command is in flight
      measuring_d = (state_d != ST_IDLE) && (cmd_d.kind == KIND_MEASURE);
      busy_d      = (state_d == ST_CONVERT);
      ymin_d      = armed_d;
      // armed flag gates the pulldown path
      xconn_d     = armed_d && !measuring_d && !force_low_d;
      irq_oe_d    = force_low_d || (xconn_d && !XPLUS_IN);
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q     <= ST_IDLE;
         cmd_q       <= '0;
         armed_q     <= ARMED_RESET;
         eligible_q  <= 1'b0;
         force_low_q <= 1'b0;
         measuring_q <= 1'b0;
         busy_q      <= 1'b0;
         ymin_q      <= ARMED_RESET;
         xconn_q     <= ARMED_RESET;
         irq_oe_q    <= 1'b0;
         irq_o_q     <= IRQ_PIN_LEVEL;
      end else begin
         state_q     <= state_d;
         cmd_q       <= cmd_d;
         armed_q     <= armed_d;
         eligible_q  <= eligible_d;
         force_low_q <= force_low_d;
         measuring_q <= measuring_d;
         busy_q      <= busy_d;
         ymin_q      <= ymin_d;
         xconn_q     <= xconn_d;
         irq_oe_q    <= irq_oe_d;
         irq_o_q     <= IRQ_PIN_LEVEL;
      end
   end

   // open drain: only ever drives low, pullup is off chip
   assign TOUCH_IRQ_N_O  = irq_o_q;
   assign TOUCH_IRQ_N_OE = irq_oe_q;
   assign YMINUS_GND_EN  = ymin_q;
   assign XPLUS_IRQ_CONN = xconn_q;
   assign PEN_ARMED      = armed_q;
   assign CONV_BUSY      = busy_q;

   localparam int A_C12 = CONV_12_CYC;
   localparam int A_C8  = CONV_8_CYC;

   a_ack_disarms: assert property (@(posedge CLK) disable iff (!RESET_N)
      ADDR_WR_ACK |=> !PEN_ARMED)
      else $error("write ack did not disarm");

   a_pd_set_disarm: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CMD_VALID && state_q == ST_IDLE && CMD.power_down_select_low != PD_SEL_ARMS)
      |=> !PEN_ARMED ##1 (!PEN_ARMED || $past(conv_done)))
      else $error("select bit set left detection armed");

   a_driver_forced: assert property (@(posedge CLK) disable iff (!RESET_N)
      (CMD_VALID && state_q == ST_IDLE && is_driver_only(CMD.kind))
      |=> TOUCH_IRQ_N_OE && !XPLUS_IRQ_CONN && !PEN_ARMED)
      else $error("driver-only command did not force pin low");

   a_measure_disconnect: assert property (@(posedge CLK) disable iff (!RESET_N)
      (state_q != ST_IDLE && cmd_q.kind == KIND_MEASURE) |-> !XPLUS_IRQ_CONN)
      else $error("X-plus connected during measurement");

   a_touch_pulls_low: assert property (@(posedge CLK) disable iff (!RESET_N)
      (XPLUS_IRQ_CONN && !XPLUS_IN && state_q == ST_IDLE && !ADDR_WR_ACK && !CMD_VALID)
      |=> TOUCH_IRQ_N_OE && TOUCH_IRQ_N_O == IRQ_PIN_LEVEL)
      else $error("touch did not pull interrupt low");

   a_conv_12bit: assert property (@(posedge CLK) disable iff (!RESET_N)
      (conv_start && cmd_q.res_8bit != RES_8BIT) |-> ##[A_C12:A_C12] conv_done)
      else $error("12-bit conversion length wrong");

   a_conv_8bit: assert property (@(posedge CLK) disable iff (!RESET_N)
      (conv_start && cmd_q.res_8bit == RES_8BIT) |-> ##[A_C8:A_C8] conv_done)
      else $error("8-bit conversion length wrong");

   a_rearm_at_done: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(PEN_ARMED) |-> $past(conv_done) && $past(eligible_q))
      else $error("armed other than at conversion end");

   a_idle_plates: assert property (@(posedge CLK) disable iff (!RESET_N)
      (PEN_ARMED && state_q == ST_IDLE) |-> YMINUS_GND_EN && XPLUS_IRQ_CONN)
      else $error("armed idle without plate connection");

   a_stop_starts_conv: assert property (@(posedge CLK) disable iff (!RESET_N)
      (state_q == ST_ACQUIRE && STOP_OR_RESTART) |=> CONV_BUSY && conv_busy)
      else $error("stop did not start conversion");
endmodule

// File: ptic_pen_irq_tb_top.sv
// self-checking bench for pen touch interrupt control
`timescale 1ns/1ps
module ptic_pen_irq_tb_top;
   import ptic_pkg::*;
   logic      clk;
   logic      reset_n;
   logic      ack;
   logic      cmd_valid;
   ptic_cmd_t cmd;
   logic      stop;
   logic      touched;
   logic      xplus;
   logic      irq_o;
   logic      irq_oe;
   logic      ym_en;
   logic      conn;
   logic      armed;
   logic      busy;
   logic      touch_irq_n;
   int        fail_count;
   int        num_checks;
   int        cycles;
   int        n;
   logic      low;

   // open-drain pin with board pullup
   assign touch_irq_n = irq_oe ? irq_o : 1'b1;

   ptic_pen_irq u_ptic_pen_irq (
      .CLK             (clk),
      .RESET_N         (reset_n),
      .ADDR_WR_ACK     (ack),
      .CMD_VALID       (cmd_valid),
      .CMD             (cmd),
      .STOP_OR_RESTART (stop),
      .XPLUS_IN        (xplus),
      .TOUCH_IRQ_N_O   (irq_o),
      .TOUCH_IRQ_N_OE  (irq_oe),
      .YMINUS_GND_EN   (ym_en),
      .XPLUS_IRQ_CONN  (conn),
      .PEN_ARMED       (armed),
      .CONV_BUSY       (busy)
   );

   ptic_panel_model u_ptic_panel_model (
      .touched       (touched),
      .yminus_gnd_en (ym_en),
      .xplus_level   (xplus)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // host side: ack, command, then stop, one pulse each
   task automatic host_write(input logic pd, input logic res, input ptic_kind_t kind);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack       <= 1'b0;
      cmd_valid <= 1'b1;
      cmd       <= '{pd, res, kind};
      @(posedge clk);
      cmd_valid <= 1'b0;
      stop      <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
   endtask

   // bounded wait for re-arm, noting any low pin level meanwhile
   task automatic wait_armed(output int cnt, output logic seen_low);
      cnt      = 0;
      seen_low = 1'b0;
      while (armed !== 1'b1 && cnt < 400) begin
         @(posedge clk);
         #1;
         cnt++;
         seen_low |= (touch_irq_n === 1'b0);
      end
   endtask

   task automatic t_reset();
      @(posedge clk);
      #1;
      check(armed, 1'b1);
      check(ym_en, 1'b1);
      check(conn, 1'b1);
      check(touch_irq_n, 1'b1);
      $display("reset done");
   endtask

   task automatic t_touch();
      @(posedge clk);
      touched <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(touch_irq_n, 1'b0);
      @(posedge clk);
      touched <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(touch_irq_n, 1'b1);
      $display("touch done");
   endtask

   // touch held through a measurement: no interrupt until re-arm
   task automatic t_measure(input logic res, input int exp_n);
      host_write(1'b0, res, KIND_MEASURE);
      touched <= 1'b1;
      #1;
      check(armed, 1'b0);
      check(conn, 1'b0);
      wait_armed(n, low);
      check(low, 1'b0);
      check(busy, 1'b0);
      check(n, exp_n);
      repeat (3) @(posedge clk);
      #1;
      check(touch_irq_n, 1'b0);
      @(posedge clk);
      touched <= 1'b0;
      $display("measure done");
   endtask

   // write ack mid-conversion cancels the pending re-arm
   task automatic t_ack_cancel();
      host_write(1'b0, 1'b0, KIND_MEASURE);
      repeat (50) @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      #1;
      check(busy, 1'b1);
      check(armed, 1'b0);
      wait_armed(n, low);
      check(n, 400);
      $display("ack cancel done");
   endtask

   task automatic t_pd_set();
      host_write(1'b1, 1'b0, KIND_MEASURE);
      touched <= 1'b1;
      wait_armed(n, low);
      check(n, 400);
      check(low, 1'b0);
      @(posedge clk);
      touched <= 1'b0;
      host_write(1'b0, 1'b1, KIND_OTHER);
      wait_armed(n, low);
      check(n, CONV_8_CYC);
      $display("power down done");
   endtask

   task automatic t_driver();
      host_write(1'b0, 1'b0, KIND_DRIVER);
      wait_armed(n, low);
      check(n, 400);
      check(touch_irq_n, 1'b0);
      check(conn, 1'b0);
      host_write(1'b0, 1'b0, KIND_MEASURE);
      wait_armed(n, low);
      check(n, CONV_12_CYC);
      check(low, 1'b0);
      $display("driver done");
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard, well above the roughly 2000 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      reset_n    = 1'b0;
      ack        = 1'b0;
      cmd_valid  = 1'b0;
      cmd        = '0;
      stop       = 1'b0;
      touched    = 1'b0;
      fail_count = 0;
      num_checks = 0;
      cycles     = 0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_touch();
      t_measure(1'b0, CONV_12_CYC);
      t_measure(1'b1, CONV_8_CYC);
      t_ack_cancel();
      t_pd_set();
      t_driver();
      conclude();
   end
endmodule

// File: ptic_pkg.sv
// shared constants and types for the pen touch interrupt control block
package ptic_pkg;
   localparam int CLK_MHZ      = 20;
   localparam int CONV_12_US   = 10;
   localparam int CONV_8_US    = 7;
   localparam int CONV_12_CYC  = CONV_12_US * CLK_MHZ;
   localparam int CONV_8_CYC   = CONV_8_US * CLK_MHZ;
   localparam int CNT_W        = 8;

   localparam logic PD_SEL_ARMS   = 1'b0;
   localparam logic RES_8BIT      = 1'b1;
   localparam logic ARMED_RESET   = 1'b1;
   localparam logic IRQ_PIN_LEVEL = 1'b0;

   typedef enum logic [1:0] {
      KIND_OTHER   = 2'b00,
      KIND_MEASURE = 2'b01,
      KIND_DRIVER  = 2'b10
   } ptic_kind_t;

   typedef struct packed {
      logic       power_down_select_low;
      logic       res_8bit;
      ptic_kind_t kind;
   } ptic_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ACQUIRE = 2'b01,
      ST_CONVERT = 2'b10
   } ptic_state_t;

   function automatic logic [CNT_W-1:0] conv_cycles(input logic res_8bit);
      conv_cycles = (res_8bit == RES_8BIT) ? CNT_W'(CONV_8_CYC) : CNT_W'(CONV_12_CYC);
   endfunction

   function automatic logic is_driver_only(input ptic_kind_t kind);
      is_driver_only = (kind == KIND_DRIVER);
   endfunction
endpackage
